// file: design/ndce_pkg.sv
// constants for the nfc direct command executor
package ndce_pkg;
  localparam longint CLK_HZ = 64'd20000000;
  localparam longint FC_HZ  = 64'd13560000;
  localparam int     CLK_NS = 50;
  // carrier-period figures
  localparam int IDT_FC   = 4096;
  localparam int ADT_FC   = 768;
  localparam int RFW_FC   = 512;
  localparam int GUNIT_FC = 64;
  localparam int IDT_CYC  = int'((IDT_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
  localparam int ADT_CYC  = int'((ADT_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
  localparam int RFW_CYC  = int'((RFW_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
  localparam int GUNIT_CYC = int'((GUNIT_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
  localparam int GBASE_NS  = 75000;
  localparam int GBASE_CYC = (GBASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int AMP_MAX_NS  = 25000;
  localparam int AMP_MAX_CYC = AMP_MAX_NS / CLK_NS;
  localparam int ADC_CONV_CYC = 32;
  // direct command codes
  localparam logic [7:0] CMD_SET_DEFAULT = 8'hc1;
  localparam logic [7:0] CMD_STOP_ALL    = 8'hc2;
  localparam logic [7:0] CMD_TX_CRC      = 8'hc4;
  localparam logic [7:0] CMD_TX_NOCRC    = 8'hc5;
  localparam logic [7:0] CMD_TX_REQA     = 8'hc6;
  localparam logic [7:0] CMD_TX_WUPA     = 8'hc7;
  localparam logic [7:0] CMD_FIELD_INIT  = 8'hc8;
  localparam logic [7:0] CMD_FIELD_RESP  = 8'hc9;
  localparam logic [7:0] CMD_MASK_RX     = 8'hd0;
  localparam logic [7:0] CMD_UNMASK_RX   = 8'hd1;
  localparam logic [7:0] CMD_CHANGE_MOD  = 8'hd2;
  localparam logic [7:0] CMD_MEAS_AMP    = 8'hd3;
  localparam logic [7:0] CMD_CLEAR_FIFO  = 8'hdb;
  // register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_CFG    = 8'h04;
  localparam logic [7:0] OFS_GUARD  = 8'h08;
  localparam logic [7:0] OFS_IRQ    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ADC    = 8'h14;
  // cfg fields
  localparam int CFG_THR_LSB = 0;
  localparam int CFG_RFW_LSB = 8;
  localparam int CFG_TYPEF   = 10;
  localparam int CFG_PTGT    = 11;
  localparam logic [11:0] CFG_RST   = 12'h000;
  localparam logic [7:0]  GUARD_RST = 8'h00;
  // irq status bits
  localparam int IRQ_APON = 0;
  localparam int IRQ_CAT  = 1;
  localparam int IRQ_CAC  = 2;
  localparam logic [1:0] AR_RST  = 2'h0;
  localparam logic [1:0] AR_STOP = 2'h1;
  typedef enum logic [1:0] {
    NDCE_IDLE, NDCE_DELAY, NDCE_GUARD, NDCE_AMP
  } ndce_state_e;
endpackage

// file: design/ndce_top.sv
// nfc direct command executor with apb register access
`timescale 1ns/100ps
module ndce_top
  import ndce_pkg::*;
#(
  parameter int IDT_CYCLES = IDT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  rf_level,
  input  wire logic [7:0]  adc_value,
  input  wire logic        tx_busy,
  input  wire logic        nrt_expired,
  input  wire logic        mrt_running,
  output logic             fifo_clr,
  output logic             tx_start,
  output logic             tx_crc,
  output logic             tx_short,
  output logic             tx_raw,
  output logic             tx_abort,
  output logic             rx_start,
  output logic             rx_masked,
  output logic             crc_check,
  output logic             timers_stop,
  output logic             temp_en_stop,
  output logic             mrt_reset,
  output logic             fdt_clear,
  output logic             rx_prep,
  output logic             tx_en,
  output logic             am_mod,
  output logic             amp_meas,
  output logic             regs_default,
  output logic [1:0]       active_response_tracking,
  output logic             irq
);

  logic [1:0]  rst_sync_ff;
  logic        rst_n_s;
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [11:0] cfg_ff;
  logic [7:0]  guard_ff;
  logic [2:0]  irq_sts_ff;
  logic [2:0]  nxt_irq_sts;
  logic        irq_ff;
  logic [7:0]  adc_res_ff;
  ndce_state_e state_ff;
  logic [15:0] cnt_ff;
  logic        init_ff;
  logic        tx_run_ff;
  logic [2:0]  irq_set;
  logic        wr_acc;
  logic        cmd_go;
  logic [7:0]  cmd;
  logic        stop_go;
  logic        busy;
  logic [15:0] rfw_cyc;
  logic [15:0] guard_cyc;

  function automatic logic is_stop(input logic [7:0] c);
    return (c == CMD_STOP_ALL) || (c == CMD_SET_DEFAULT);
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_ff[1];

  // one wait state keeps every bus output registered
  assign wr_acc  = psel && penable && pready_ff && pwrite;
  assign cmd_go  = wr_acc && (paddr == OFS_CMD);
  assign cmd     = pwdata[7:0];
  assign stop_go = cmd_go && is_stop(cmd);
  assign busy    = (state_ff != NDCE_IDLE);
  assign rfw_cyc = 16'(RFW_CYC) * {14'h0, cfg_ff[CFG_RFW_LSB +: 2]};
  assign guard_cyc = 16'(GBASE_CYC)
                   + 16'(GUNIT_CYC) * {8'h0, guard_ff};

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
      if (psel && penable && !pready_ff) begin
        unique case (paddr)
          OFS_CMD:    prdata_ff <= 32'h0;
          OFS_CFG:    prdata_ff <= {20'h0, cfg_ff};
          OFS_GUARD:  prdata_ff <= {24'h0, guard_ff};
          OFS_IRQ:    prdata_ff <= {29'h0, irq_sts_ff};
          OFS_STATUS: prdata_ff <= {23'h0, state_ff, tx_run_ff,
                                    active_response_tracking, crc_check,
                                    rx_masked, am_mod, tx_en};
          OFS_ADC:    prdata_ff <= {24'h0, adc_res_ff};
          default:    pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cfg_ff   <= CFG_RST;
      guard_ff <= GUARD_RST;
    end else if (cmd_go && cmd == CMD_SET_DEFAULT) begin
      cfg_ff   <= CFG_RST;
      guard_ff <= GUARD_RST;
    end else if (wr_acc && paddr == OFS_CFG) begin
      cfg_ff <= pwdata[11:0];
    end else if (wr_acc && paddr == OFS_GUARD) begin
      guard_ff <= pwdata[7:0];
    end
  end

  // hardware set wins over software write-one-to-clear
  always_comb begin
    nxt_irq_sts = irq_sts_ff;
    if (stop_go) begin
      nxt_irq_sts = 3'h0;
    end else if (wr_acc && paddr == OFS_IRQ) begin
      nxt_irq_sts = irq_sts_ff & ~pwdata[2:0];
    end
    nxt_irq_sts = nxt_irq_sts | irq_set;
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_sts_ff <= 3'h0;
      irq_ff     <= 1'b0;
    end else begin
      irq_sts_ff <= nxt_irq_sts;
      irq_ff     <= |nxt_irq_sts;
    end
  end

  // field-on and amplitude sequencer
  always_comb begin
    irq_set = 3'h0;
    if (!stop_go && state_ff == NDCE_DELAY && cnt_ff == 16'h0) begin
      if (rf_level >= cfg_ff[CFG_THR_LSB +: 8]) begin
        irq_set[IRQ_CAC] = 1'b1;
      end else begin
        irq_set[IRQ_APON] = 1'b1;
      end
    end
    if (!stop_go && state_ff == NDCE_GUARD && cnt_ff == 16'h0) begin
      irq_set[IRQ_CAT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_ff   <= NDCE_IDLE;
      cnt_ff     <= 16'h0;
      init_ff    <= 1'b0;
      adc_res_ff <= 8'h0;
    end else if (stop_go) begin
      state_ff <= NDCE_IDLE;
      cnt_ff   <= 16'h0;
    end else begin
      unique case (state_ff)
        NDCE_IDLE: begin
          if (cmd_go && cmd == CMD_FIELD_INIT) begin
            state_ff <= NDCE_DELAY;
            cnt_ff   <= 16'(IDT_CYCLES) + rfw_cyc - 16'h1;
          end else if (cmd_go && cmd == CMD_FIELD_RESP) begin
            state_ff <= NDCE_DELAY;
            cnt_ff   <= 16'(ADT_CYC) + rfw_cyc - 16'h1;
          end else if (cmd_go && cmd == CMD_MEAS_AMP) begin
            state_ff <= NDCE_AMP;
            cnt_ff   <= 16'(ADC_CONV_CYC - 1);
          end
        end
        NDCE_DELAY: begin
          if (cnt_ff != 16'h0) begin
            cnt_ff <= cnt_ff - 16'h1;
          end else if (irq_set[IRQ_CAC]) begin
            state_ff <= NDCE_IDLE;
          end else begin
            state_ff <= NDCE_GUARD;
            cnt_ff   <= guard_cyc - 16'h1;
          end
        end
        NDCE_GUARD: begin
          if (cnt_ff != 16'h0) begin
            cnt_ff <= cnt_ff - 16'h1;
          end else begin
            state_ff <= NDCE_IDLE;
          end
        end
        NDCE_AMP: begin
          if (cnt_ff != 16'h0) begin
            cnt_ff <= cnt_ff - 16'h1;
          end else begin
            adc_res_ff <= adc_value;
            state_ff   <= NDCE_IDLE;
          end
        end
      endcase
    end
  end

  // transmitter enable, modulation, receive masking
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tx_en     <= 1'b0;
      am_mod    <= 1'b0;
      amp_meas  <= 1'b0;
      rx_masked <= 1'b0;
      crc_check <= 1'b1;
    end else begin
      amp_meas <= (state_ff == NDCE_AMP) && !stop_go;
      if (cmd_go && cmd == CMD_SET_DEFAULT) begin
        tx_en     <= 1'b0;
        am_mod    <= 1'b0;
        rx_masked <= 1'b0;
        crc_check <= 1'b1;
      end else begin
        // stop-all leaves tx_en alone, so an active field stays on
        if (irq_set[IRQ_APON]) begin
          tx_en <= 1'b1;
        end
        if (cmd_go && cmd == CMD_CHANGE_MOD) begin
          am_mod <= !am_mod;
        end
        if (cmd_go && cmd == CMD_MASK_RX) begin
          rx_masked <= 1'b1;
        end else if (cmd_go && cmd == CMD_UNMASK_RX) begin
          rx_masked <= 1'b0;
        end
        if (cmd_go && (cmd == CMD_TX_REQA || cmd == CMD_TX_WUPA)) begin
          crc_check <= 1'b0;
        end else if (nrt_expired
                     || (cmd_go && cmd == CMD_TX_CRC)
                     || (cmd_go && cmd == CMD_MASK_RX)) begin
          crc_check <= 1'b1;
        end
      end
    end
  end

  // one-cycle command strobes to the datapath
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      fifo_clr     <= 1'b0;
      tx_start     <= 1'b0;
      tx_crc       <= 1'b0;
      tx_short     <= 1'b0;
      tx_raw       <= 1'b0;
      tx_abort     <= 1'b0;
      timers_stop  <= 1'b0;
      temp_en_stop <= 1'b0;
      mrt_reset    <= 1'b0;
      fdt_clear    <= 1'b0;
      rx_prep      <= 1'b0;
      regs_default <= 1'b0;
    end else begin
      fifo_clr     <= stop_go || (cmd_go && cmd == CMD_CLEAR_FIFO);
      tx_abort     <= stop_go
                      || (cmd_go && cmd == CMD_CLEAR_FIFO && tx_busy);
      timers_stop  <= stop_go;
      temp_en_stop <= stop_go;
      regs_default <= cmd_go && cmd == CMD_SET_DEFAULT;
      tx_start     <= cmd_go && (cmd == CMD_TX_CRC || cmd == CMD_TX_NOCRC
                      || cmd == CMD_TX_REQA || cmd == CMD_TX_WUPA);
      tx_crc       <= cmd_go && cmd == CMD_TX_CRC;
      tx_short     <= cmd_go && (cmd == CMD_TX_REQA || cmd == CMD_TX_WUPA);
      tx_raw       <= cmd_go && cmd == CMD_TX_NOCRC
                      && cfg_ff[CFG_TYPEF];
      mrt_reset    <= cmd_go && cmd == CMD_UNMASK_RX
                      && mrt_running;
      fdt_clear    <= stop_go || (cmd_go && cmd == CMD_UNMASK_RX
                      && cfg_ff[CFG_PTGT]);
      rx_prep      <= cmd_go && cmd == CMD_UNMASK_RX
                      && cfg_ff[CFG_PTGT];
    end
  end

  // transmit tracking for the automatic switch into reception
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tx_run_ff                <= 1'b0;
      rx_start                 <= 1'b0;
      active_response_tracking <= AR_RST;
    end else begin
      rx_start <= tx_run_ff && !tx_busy && !stop_go;
      if (stop_go || tx_abort) begin
        tx_run_ff <= 1'b0;
      end else if (tx_start) begin
        tx_run_ff <= 1'b1;
      end else if (!tx_busy) begin
        tx_run_ff <= 1'b0;
      end
      if (stop_go) begin
        active_response_tracking <= AR_STOP;
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

  sequence s_delay_end;
    state_ff == NDCE_DELAY && cnt_ff == 16'h0 && !stop_go;
  endsequence

  chk_stop_clears_irq: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    stop_go |=> irq_sts_ff == 3'h0 && !irq_ff)
    else $error("stop left interrupt status set");

  chk_stop_no_field: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    stop_go && state_ff == NDCE_DELAY
    |=> $stable(tx_en) && state_ff == NDCE_IDLE)
    else $error("stop during avoidance changed field");

  chk_stop_ar: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    stop_go |=> active_response_tracking == AR_STOP && temp_en_stop)
    else $error("stop did not set tracking field");

  chk_fifo_keep_irq: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    cmd_go && cmd == CMD_CLEAR_FIFO && irq_set == 3'h0
    && !(wr_acc && paddr == OFS_IRQ)
    |=> fifo_clr && irq_sts_ff == $past(irq_sts_ff))
    else $error("clear fifo disturbed interrupts");

  chk_fifo_abort: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    cmd_go && cmd == CMD_CLEAR_FIFO && tx_busy |=> tx_abort && fifo_clr)
    else $error("clear fifo did not abort transmit");

  chk_reqa_crc: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    cmd_go && cmd == CMD_TX_REQA |=> !crc_check)
    else $error("short frame left crc check on");

  chk_field_on: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    s_delay_end and (rf_level < cfg_ff[7:0])
    |=> tx_en && irq_sts_ff[IRQ_APON] && state_ff == NDCE_GUARD)
    else $error("field not switched on");

  chk_field_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    s_delay_end and (rf_level >= cfg_ff[7:0]) and !tx_en
    |=> !tx_en && irq_sts_ff[IRQ_CAC])
    else $error("collision not reported");

  chk_mod_toggle: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    cmd_go && cmd == CMD_CHANGE_MOD && !stop_go |=> am_mod != $past(am_mod))
    else $error("modulation state not toggled");

  chk_amp_time: assert property (
    @(posedge ref_clk) disable iff (!rst_n_s)
    state_ff == NDCE_IDLE && cmd_go && cmd == CMD_MEAS_AMP
    |=> ##[1:40] state_ff == NDCE_IDLE)
    else $error("amplitude measure too slow");

endmodule

// file: tb/ndce_datapath_model.sv
// stand-in for the transmit datapath and the amplitude converter
`timescale 1ns/100ps
module ndce_datapath_model #(
  parameter int         TX_LEN   = 8,
  parameter logic [7:0] AMP_CODE = 8'he6
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       tx_start,
  input  wire logic       tx_abort,
  input  wire logic       amp_meas,
  output logic            tx_busy,
  output logic [7:0]      adc_value
);
  int         cnt_ff;
  logic [7:0] pat_ff;
  // an abort ends the frame at once, the busy level drops with it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 0;
    end else if (tx_abort) begin
      cnt_ff <= 0;
    end else if (tx_start) begin
      cnt_ff <= TX_LEN;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  // outside a measurement the converter output wanders
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pat_ff <= 8'h5a;
    end else begin
      pat_ff <= pat_ff + 8'h3b;
    end
  end
  assign tx_busy   = (cnt_ff != 0);
  assign adc_value = amp_meas ? AMP_CODE : pat_ff;
endmodule

// file: tb/nfc_direct_command_effects_test.sv
// self-checking bench for the direct command executor
`timescale 1ns/100ps
module nfc_direct_command_effects_test;
  import ndce_pkg::*;
  localparam int IDT_SIM = 20;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        nrt_expired, mrt_running, tx_busy, clr_seen, err;
  logic [7:0]  paddr, rf_level, adc_value;
  logic [31:0] pwdata, prdata, rd;
  logic        fifo_clr, tx_start, tx_crc, tx_short, tx_raw, tx_abort;
  logic        rx_start, rx_masked, crc_check, timers_stop, temp_en_stop;
  logic        mrt_reset, fdt_clear, rx_prep, tx_en, am_mod, amp_meas;
  logic        regs_default, irq;
  logic [1:0]  active_response_tracking;
  logic [12:0] seen, strb;
  int          bad_count, n_tests, cyc;

  ndce_top #(
    .IDT_CYCLES(IDT_SIM)
  ) u_ndce_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rf_level(rf_level), .adc_value(adc_value), .tx_busy(tx_busy),
    .nrt_expired(nrt_expired), .mrt_running(mrt_running),
    .fifo_clr(fifo_clr), .tx_start(tx_start), .tx_crc(tx_crc),
    .tx_short(tx_short), .tx_raw(tx_raw), .tx_abort(tx_abort),
    .rx_start(rx_start), .rx_masked(rx_masked), .crc_check(crc_check),
    .timers_stop(timers_stop), .temp_en_stop(temp_en_stop),
    .mrt_reset(mrt_reset), .fdt_clear(fdt_clear), .rx_prep(rx_prep),
    .tx_en(tx_en), .am_mod(am_mod), .amp_meas(amp_meas),
    .regs_default(regs_default),
    .active_response_tracking(active_response_tracking), .irq(irq));
  ndce_datapath_model u_ndce_datapath_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .tx_start(tx_start),
    .tx_abort(tx_abort), .amp_meas(amp_meas), .tx_busy(tx_busy),
    .adc_value(adc_value));

  // sticky record of strobes so one-cycle pulses are never missed
  assign strb = {fifo_clr, tx_start, tx_crc, tx_short, tx_raw, tx_abort,
                 rx_start, timers_stop, temp_en_stop, mrt_reset, fdt_clear,
                 rx_prep, regs_default};
  always @(posedge ref_clk) begin
    if (!rst_n || clr_seen) begin
      seen <= 13'h0;
    end else begin
      seen <= seen | strb;
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    clr_seen <= w;
    @(posedge ref_clk);
    penable <= 1'b1;
    clr_seen <= 1'b0;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic cmd(input logic [7:0] c);
    apb(1'b1, OFS_CMD, {24'h0, c});
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic wait_hi(input bit sel);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      cyc++;
    end while ((sel ? irq : tx_en) !== 1'b1 && cyc < 5000);
  endtask

  task automatic inrange(input string nm, input int e, input int lo,
                         input int hi);
    chk(nm, 32'h1, {31'h0, cyc >= e - lo && cyc <= e + hi});
  endtask

  task automatic t_reset_bus();
    chk("crc_check", 1, crc_check);
    chk("outs", 0, {tx_en, am_mod, rx_masked, irq, active_response_tracking});
    rdchk("status", OFS_STATUS, 32'h8);
    rdchk("cfg", OFS_CFG, {20'h0, CFG_RST});
    rdchk("guard", OFS_GUARD, {24'h0, GUARD_RST});
    apb(1'b1, 8'h18, 32'hff);
    chk("slverr", 1, err);
    rdchk("unmapped", 8'h18, 32'h0);
    chk("slverr rd", 1, err);
    rdchk("cmd rd", OFS_CMD, 32'h0);
  endtask

  task automatic t_mod_mask();
    for (int i = 0; i < 2; i++) begin
      cmd(CMD_CHANGE_MOD);
      chk("am_mod", i == 0, am_mod);
    end
    cmd(CMD_MASK_RX);
    chk("masked", 1, rx_masked);
    mrt_running <= 1'b1;
    cmd(CMD_UNMASK_RX);
    chk("unmasked", 0, rx_masked);
    chk("mrt_reset", 13'h8, seen & 13'h8);
    mrt_running <= 1'b0;
    apb(1'b1, OFS_CFG, 32'h800);
    cmd(CMD_UNMASK_RX);
    chk("ptgt unmask", 13'h6, seen & 13'h6);
  endtask

  task automatic t_tx();
    apb(1'b1, OFS_CFG, 32'h0);
    for (int i = 0; i < 3; i++) begin
      cmd(i == 1 ? CMD_TX_WUPA : CMD_TX_REQA);
      chk("short tx", 13'ha00, seen & 13'ha00);
      chk("crc off", 0, crc_check);
      repeat (12) @(posedge ref_clk);
      chk("rx after tx", 13'h40, seen & 13'h40);
      if (i == 0) cmd(CMD_MASK_RX);
      if (i == 1) begin
        nrt_expired <= 1'b1;
        @(posedge ref_clk);
        nrt_expired <= 1'b0;
        repeat (2) @(posedge ref_clk);
      end
      if (i == 2) begin
        cmd(CMD_CLEAR_FIFO);
        cmd(CMD_TX_CRC);
        chk("crc tx", 13'hc00, seen & 13'hc00);
      end
      chk("crc on", 1, crc_check);
    end
    cmd(CMD_UNMASK_RX);
    apb(1'b1, OFS_CFG, 32'h400);
    cmd(CMD_TX_NOCRC);
    chk("raw tx", 13'h900, seen & 13'h900);
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic t_field_init();
    apb(1'b1, OFS_CFG, 32'h180);
    apb(1'b1, OFS_GUARD, 32'h1);
    rf_level <= 8'h10;
    apb(1'b1, OFS_CMD, {24'h0, CMD_FIELD_INIT});
    wait_hi(1'b0);
    inrange("init delay", IDT_SIM + RFW_CYC, 2, 4);
    @(posedge ref_clk);
    chk("apon irq", 1, irq);
    rdchk("irq apon", OFS_IRQ, 32'h1);
    apb(1'b1, OFS_IRQ, 32'h1);
    chk("w1c", 0, irq);
    wait_hi(1'b1);
    inrange("guard", GBASE_CYC + GUNIT_CYC, 14, 2);
    rdchk("irq cat", OFS_IRQ, 32'h2);
  endtask

  task automatic t_clr_stop();
    cmd(CMD_TX_NOCRC);
    cmd(CMD_CLEAR_FIFO);
    chk("abort", 13'h1080, seen & 13'h1080);
    chk("irq kept", 1, irq);
    cmd(CMD_STOP_ALL);
    chk("stop strb", 13'h1030, seen & 13'h1030);
    chk("stop irq", 0, irq);
    rdchk("stop irqst", OFS_IRQ, 32'h0);
    chk("field kept", 1, tx_en);
    chk("tracking", 2'b01, active_response_tracking);
    cmd(CMD_SET_DEFAULT);
    chk("default", 13'h1, seen & 13'h1);
    chk("def tx", 0, {tx_en, irq});
    rdchk("def cfg", OFS_CFG, 32'h0);
    apb(1'b1, OFS_CFG, 32'h80);
    cmd(CMD_FIELD_INIT);
    repeat (5) @(posedge ref_clk);
    cmd(CMD_STOP_ALL);
    repeat (2000) @(posedge ref_clk);
    chk("stopped field", 0, {tx_en, irq});
  endtask

  task automatic t_resp_amp();
    apb(1'b1, OFS_CFG, 32'h40);
    rf_level <= 8'h40;
    apb(1'b1, OFS_CMD, {24'h0, CMD_FIELD_RESP});
    wait_hi(1'b1);
    inrange("resp delay", ADT_CYC, 2, 4);
    chk("tx off", 0, tx_en);
    rdchk("irq cac", OFS_IRQ, 32'h4);
    apb(1'b1, OFS_CMD, {24'h0, CMD_MEAS_AMP});
    // the enable settles after the edge on which the task returns
    @(posedge ref_clk);
    chk("meas", 1, amp_meas);
    repeat (AMP_MAX_CYC - 5) @(posedge ref_clk);
    rdchk("adc", OFS_ADC, 32'he6);
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, nrt_expired, mrt_running, clr_seen} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rf_level = 8'h0;
    bad_count = 0;
    n_tests = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset_bus();
    t_mod_mask();
    t_tx();
    t_field_init();
    t_clr_stop();
    t_resp_amp();
    print_verdict();
  end

  // whole run is near 6250 cycles; a hang stops here
  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
endmodule
